/* File: seq_irq_ctrl.sv */
// Summary of operation
// (RULE1) stall: finish current, cancel and refetch next
// (RULE2) cancelled instruction updates no register or flag; a cancelled first return still sets master enable and reloads cfa
// (RULE3) three active-low level irq lines, sampled
// (RULE4) every active source sets its status flag
// (RULE5) honour only with master and own enable
// (RULE6) flags stay set until full-word write
// (RULE7) breakpoint compare only while its enable set
// (RULE8) entry saves fetch and next-fetch addresses
// (RULE9) entry neutralizes shadow, vectors, saves branch bit
// (RULE10) vector is base OR four class bits
// (RULE11) simultaneous interrupts: all class bits set
// (RULE12) first return reloads saved-execute, sets enable
// (RULE13) second return reloads saved-fetch address
// (RULE14) first return ignores the stall input
// (RULE15) system gates code word bit with stall
// (RULE16) interrupt entry overrides stall
// (RULE17) each external line has enable and flag
// (RULE18) stack high: push while pointer is 29
// (RULE19) stack low: pop while pointer 1, 0, 31
// (RULE20) trap instruction sets trap flag
// (RULE21) timer expiry and breakpoint hit set flags
// (RULE22) breakpoint stops before matching instruction, even neutralized
// (RULE23) keep shadow, keep and increment, invert
// (RULE24) neutralize output after branches, entries, returns
// (RULE25) external sources hold requests until acknowledged
// (RULE26) reset: zeros, reserved one bit, pointer all ones
// (RULE27) source-to-class mapping is a parameter
// (RULE28) no entry while master enable clear
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module seq_irq_ctrl
    import seq_irq_pkg::*;
#(
    parameter logic [31:0] CLASS_MAP = seq_irq_pkg::CLASS_MAP_DEF // RULE27
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire seq_irq_pkg::wb_req_t  wb_req_i,
    output seq_irq_pkg::wb_rsp_t       wb_rsp_o,
    input  wire seq_irq_pkg::seq_op_t  op_i,
    input  wire logic                  timer_neg_i,
    input  wire logic                  stall_n_i,
    input  wire logic                  ext_irq_a_n_i,
    input  wire logic                  ext_irq_b_n_i,
    input  wire logic                  ext_irq_c_n_i,
    output logic [21:0]                code_addr_out_o,
    output logic                       shadow_cancel_n_o,
    output logic                       exec_cancel_o,
    output logic                       irq_entry_o
);
    import seq_irq_pkg::*;

    logic [31:0]      ssr;
    logic [31:0]      next_ssr;
    logic [31:0]      ibr;
    logic [31:0]      brk;
    logic [21:0]      cfa;
    logic [21:0]      iea;
    logic [21:0]      ifa;
    logic [3:0]       pins_s;
    logic             stall_act;
    logic             cancel_q;
    logic             exec_ok;
    logic [NSRC-1:0]  src_ev;
    logic [NSRC-1:0]  en_vec;
    logic [NSRC-1:0]  flag_set;
    logic [NSRC-1:0]  approved;
    logic [NCLS-1:0]  cls [NSRC];
    logic [NCLS-1:0]  cls_all;
    logic [31:0]      vector;
    logic             take;
    logic             men;
    logic [4:0]       tos;
    logic             wb_req;
    logic             wb_wr;
    logic             wr_ssr;
    logic [31:0]      rd_data;
    logic             shadow_cancel_n;
    logic             ret_second_ok;

    // ext lines and stall come from pins: three-stage synchroniser
    pin_sync #(
        .WIDTH     (4),
        .RESET_VAL (4'hf)
    ) u_pins (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .pin_i  ({stall_n_i, ext_irq_c_n_i, ext_irq_b_n_i, ext_irq_a_n_i}),
        .sync_o (pins_s)
    ); // RULE3

    assign stall_act = !pins_s[3];
    assign men       = ssr[MEN_POS];
    assign tos       = ssr[TOS_LO +: 5];

    // the instruction after a stalled cycle is the cancelled one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cancel_q <= 1'b0;
        end else if (ce_i) begin
            cancel_q <= stall_act; // RULE1
        end
    end
    assign exec_ok       = !cancel_q; // RULE2
    assign ret_second_ok = op_i.ret_second && exec_ok;

    // event sources; instruction-driven ones are dropped when cancelled
    always_comb begin
        src_ev          = '0;
        src_ev[SRC_BRK] = ssr[BRKEN_POS] && (cfa == brk[21:0]); // RULE7 RULE22
        src_ev[SRC_TIM] = timer_neg_i; // RULE21
        src_ev[SRC_SOV] = exec_ok && op_i.push
                          && (tos == TOS_HIGH_MARK); // RULE18
        src_ev[SRC_SUN] = exec_ok && op_i.pop
                          && (tos == TOS_LOW_A || tos == TOS_LOW_B
                              || tos == TOS_LOW_C); // RULE19
        src_ev[SRC_TRP] = exec_ok && op_i.trap; // RULE20
        src_ev[SRC_EXC] = !pins_s[2]; // RULE17
        src_ev[SRC_EXB] = !pins_s[1]; // RULE17
        src_ev[SRC_EXA] = !pins_s[0]; // RULE17
    end

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_src
            assign en_vec[g]   = ssr[EN_POS[g]];
            assign flag_set[g] = src_ev[g]; // RULE4
            assign approved[g] = src_ev[g] && en_vec[g]; // RULE5
            assign cls[g]      = approved[g] ? CLASS_MAP[4*g +: 4] : 4'h0;
        end
    endgenerate

    // no priority: every approved source contributes its class bits
    always_comb begin
        cls_all = 4'h0;
        for (int i = 0; i < NSRC; i++) begin
            cls_all = cls_all | cls[i]; // RULE11
        end
    end

    assign vector = ibr | {28'h000_0000, cls_all}; // RULE10
    // entry wins over stall and over the returns
    assign take   = men && (|approved) && (cls_all != 4'h0); // RULE28 RULE16

    // status word
    always_comb begin
        next_ssr = ssr;
        if (exec_ok && (op_i.push || op_i.keep_shadow_inc)) begin
            next_ssr[TOS_LO +: 5] = tos + 5'd1; // RULE23
        end else if (exec_ok && op_i.pop) begin
            next_ssr[TOS_LO +: 5] = tos - 5'd1;
        end
        if (exec_ok) begin
            next_ssr[B_POS] = op_i.branch;
        end
        if (take) begin
            next_ssr[BI_POS]  = ssr[B_POS]; // RULE9
            next_ssr[MEN_POS] = 1'b0;
        end else if (op_i.ret_first) begin
            next_ssr[MEN_POS] = 1'b1; // RULE12 RULE14
        end
        if (wr_ssr) begin
            next_ssr = wb_req_i.dat; // RULE6
        end
        // a source firing in the clearing cycle still lands
        for (int i = 0; i < NSRC; i++) begin
            if (flag_set[i]) begin
                next_ssr[FLAG_POS[i]] = 1'b1; // RULE4 RULE6
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ssr <= SSR_RESET; // RULE26
        end else if (ce_i) begin
            ssr <= next_ssr;
        end
    end

    // fetch address and saved return addresses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfa <= CFA_RESET;
            iea <= CFA_RESET;
            ifa <= CFA_RESET;
        end else if (ce_i) begin
            if (take) begin
                iea <= cfa; // RULE8
                ifa <= op_i.next_addr; // RULE8
                cfa <= vector[21:0]; // RULE9 RULE16
            end else if (op_i.ret_first) begin
                cfa <= iea; // RULE12 RULE14
            end else if (stall_act) begin
                cfa <= cfa; // RULE1
            end else if (ret_second_ok) begin
                cfa <= ifa; // RULE13
            end else begin
                cfa <= op_i.next_addr;
            end
        end
    end

    // the pin is driven from the register so no decode logic sits on it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_addr_out_o <= CFA_RESET;
            exec_cancel_o   <= 1'b0;
            irq_entry_o     <= 1'b0;
        end else if (ce_i) begin
            if (take) begin
                code_addr_out_o <= vector[21:0];
            end else if (op_i.ret_first) begin
                code_addr_out_o <= iea; // RULE12
            end else if (!stall_act && ret_second_ok) begin
                code_addr_out_o <= ifa; // RULE13
            end else if (!stall_act) begin
                code_addr_out_o <= op_i.next_addr;
            end
            exec_cancel_o <= stall_act;
            irq_entry_o   <= take;
        end
    end

    // shadow neutralization
    always_comb begin
        shadow_cancel_n = (exec_ok && op_i.branch) || take || op_i.ret_first
               || ret_second_ok; // RULE24
        if (exec_ok && (op_i.keep_shadow || op_i.keep_shadow_inc)) begin
            shadow_cancel_n = 1'b0; // RULE23
        end else if (exec_ok && op_i.invert_shadow) begin
            shadow_cancel_n = !shadow_cancel_n; // RULE23
        end
        if (take) begin
            shadow_cancel_n = 1'b1; // RULE9
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow_cancel_n_o <= 1'b1;
        end else if (ce_i) begin
            shadow_cancel_n_o <= !shadow_cancel_n; // RULE24
        end
    end

    // wishbone slave: ack one cycle after the request, write at ack edge
    assign wb_req = wb_req_i.cyc && wb_req_i.stb;
    assign wb_wr  = wb_req && wb_req_i.we && wb_rsp_o.ack;
    // only a complete word may overwrite the status word
    assign wr_ssr = wb_wr && (wb_req_i.adr == OFF_SSR)
                    && (wb_req_i.sel == 4'hf); // RULE6

    always_comb begin
        if (wb_req_i.adr == OFF_SSR) begin
            rd_data = ssr;
        end else if (wb_req_i.adr == OFF_IBR) begin
            rd_data = ibr;
        end else if (wb_req_i.adr == OFF_BRK) begin
            rd_data = brk;
        end else if (wb_req_i.adr == OFF_IEA) begin
            rd_data = {10'h000, iea};
        end else if (wb_req_i.adr == OFF_IFA) begin
            rd_data = {10'h000, ifa};
        end else if (wb_req_i.adr == OFF_CFA) begin
            rd_data = {10'h000, cfa};
        end else begin
            rd_data = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_rsp_o <= '0;
        end else if (ce_i) begin
            wb_rsp_o.ack <= wb_req && !wb_rsp_o.ack;
            if (wb_req && !wb_rsp_o.ack) begin
                wb_rsp_o.dat <= rd_data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ibr <= IBR_RESET;
            brk <= BRK_RESET;
        end else if (ce_i && wb_wr) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_req_i.sel[i] && wb_req_i.adr == OFF_IBR) begin
                    ibr[8*i +: 8] <= wb_req_i.dat[8*i +: 8];
                end
                if (wb_req_i.sel[i] && wb_req_i.adr == OFF_BRK) begin
                    brk[8*i +: 8] <= wb_req_i.dat[8*i +: 8];
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence s_take;
        take;
    endsequence

    sequence s_entry_done;
        !shadow_cancel_n_o && irq_entry_o;
    endsequence

    a_entry_needs_men: assert property (irq_entry_o |-> $past(men)) // RULE28
        else $error("entry taken with master enable clear");
    a_vector_load: assert property (s_take |=> // RULE10
        cfa == $past(vector[21:0]) && code_addr_out_o == cfa)
        else $error("vector address not loaded on entry");
    a_ret_saved: assert property (s_take |=> // RULE8
        iea == $past(cfa) && ifa == $past(op_i.next_addr))
        else $error("return addresses not saved on entry");
    a_entry_shadow: assert property (s_take |=> s_entry_done) // RULE9
        else $error("entry did not neutralize the shadow");
    a_stall_hold: assert property (stall_act && !take // RULE1
        && !op_i.ret_first |=> $stable(cfa))
        else $error("fetch address moved during stall");
    a_ret_first_men: assert property (op_i.ret_first && !take // RULE12
        |=> men && cfa == $past(iea))
        else $error("first return did not restore address and enable");
    a_brk_disabled: assert property (!ssr[BRKEN_POS] // RULE7
        |=> !(ssr[FLAG_POS[SRC_BRK]]
              && !$past(ssr[FLAG_POS[SRC_BRK]])))
        else $error("breakpoint flag set while disabled");
    a_flag_sticky: assert property (ssr[FLAG_POS[SRC_TRP]] && !wr_ssr // RULE6
        |=> ssr[FLAG_POS[SRC_TRP]])
        else $error("trap flag dropped without a full write");
    a_cancel_no_trap: assert property (cancel_q && op_i.trap // RULE2
        && !ssr[FLAG_POS[SRC_TRP]] && !wr_ssr
        |=> !ssr[FLAG_POS[SRC_TRP]])
        else $error("cancelled trap set its flag");
    a_stack_high: assert property (exec_ok && op_i.push // RULE18
        && tos == TOS_HIGH_MARK |=> ssr[FLAG_POS[SRC_SOV]])
        else $error("stack high flag missing");
    a_ack_pulse: assert property (wb_req && !wb_rsp_o.ack
        |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("ack not a single-cycle answer");

endmodule // seq_irq_ctrl

/* File: seq_irq_pkg.sv */
package seq_irq_pkg;

    localparam int ADDR_W = 22;
    localparam int NSRC   = 8;
    localparam int NCLS   = 4;

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_SSR = 8'h00;
    localparam logic [7:0] OFF_IBR = 8'h04;
    localparam logic [7:0] OFF_BRK = 8'h08;
    localparam logic [7:0] OFF_IEA = 8'h0c;
    localparam logic [7:0] OFF_IFA = 8'h10;
    localparam logic [7:0] OFF_CFA = 8'h14;

    localparam logic [31:0] SSR_RESET = 32'hf800_0010;
    localparam logic [31:0] IBR_RESET = 32'h0000_0000;
    localparam logic [31:0] BRK_RESET = 32'h0000_0000;
    localparam logic [21:0] CFA_RESET = 22'h00_0000;

    // status word fields
    localparam int B_POS   = 2;
    localparam int BI_POS  = 3;
    localparam int MEN_POS = 26;
    localparam int TOS_LO  = 27;
    localparam int BRKEN_POS = 7;

    // source order: brk, tim, stack high, stack low, trap, c, b, a
    localparam int SRC_BRK = 0;
    localparam int SRC_TIM = 1;
    localparam int SRC_SOV = 2;
    localparam int SRC_SUN = 3;
    localparam int SRC_TRP = 4;
    localparam int SRC_EXC = 5;
    localparam int SRC_EXB = 6;
    localparam int SRC_EXA = 7;
    localparam int FLAG_POS [NSRC] = '{6, 9, 11, 13, 15, 19, 22, 24};
    localparam int EN_POS   [NSRC] = '{7, 10, 12, 14, 16, 20, 21, 25};

    // one nibble of class bits per source, source 0 lowest
    localparam logic [31:0] CLASS_MAP_DEF = 32'h8842_2211;

    localparam logic [4:0] TOS_HIGH_MARK = 5'd29;
    localparam logic [4:0] TOS_LOW_A     = 5'd1;
    localparam logic [4:0] TOS_LOW_B     = 5'd0;
    localparam logic [4:0] TOS_LOW_C     = 5'd31;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // decoded instruction now executing, from the decode stage
    typedef struct packed {
        logic        branch;
        logic        push;
        logic        pop;
        logic        trap;
        logic        ret_first;
        logic        ret_second;
        logic        keep_shadow;
        logic        keep_shadow_inc;
        logic        invert_shadow;
        logic [21:0] next_addr;
    } seq_op_t;

endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int             WIDTH     = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic ff1;
            logic ff2;
            logic ff3;
            // ff1 feeds ff2 only; a change is taken once ff2 and ff3 agree
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ff1       <= RESET_VAL[g];
                    ff2       <= RESET_VAL[g];
                    ff3       <= RESET_VAL[g];
                    sync_o[g] <= RESET_VAL[g];
                end else if (ce_i) begin
                    ff1 <= pin_i[g];
                    ff2 <= ff1;
                    ff3 <= ff2;
                    if (ff2 == ff3) begin
                        sync_o[g] <= ff3;
                    end
                end
            end
        end
    endgenerate
endmodule // pin_sync

/* File: irq_env_model.sv */
`timescale 1ns/1ps
module irq_env_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] raise_i,
    input  wire logic [2:0] ack_i,
    input  wire logic       stall_i,
    output logic      [2:0] line_n_o,
    output logic            stall_n_o
);
    // a request stays low until the handler acknowledges it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_n_o <= 3'b111;
        end else begin
            line_n_o <= (line_n_o & ~raise_i) | ack_i;
        end
    end
    // slow memory side: stall is a level held as long as asked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stall_n_o <= 1'b1;
        end else begin
            stall_n_o <= ~stall_i;
        end
    end
endmodule // irq_env_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import seq_irq_pkg::*;
    localparam logic [31:0] MEN = 32'h0400_0000;
    logic        clk_i;
    logic        rst_i;
    wb_req_t     req;
    wb_rsp_t     rsp;
    seq_op_t     op;
    logic        timer;
    logic [2:0]  raise;
    logic [2:0]  ack;
    logic        stall;
    logic [2:0]  line_n;
    logic        stall_n;
    logic [21:0] code_addr;
    logic        shadow_cancel_n_n;
    logic        canc;
    logic        entry;
    logic [31:0] q;
    logic [4:0]  tv [5] = '{5'd29, 5'd28, 5'd1, 5'd0, 5'd31};
    logic [31:0] ev [5] = '{32'h800, 32'h0, 32'h2000, 32'h2000, 32'h2000};
    int          n_fail;
    int          checks;

    seq_irq_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_req_i(req), .wb_rsp_o(rsp), .op_i(op), .timer_neg_i(timer),
        .stall_n_i(stall_n), .ext_irq_a_n_i(line_n[0]),
        .ext_irq_b_n_i(line_n[1]), .ext_irq_c_n_i(line_n[2]),
        .code_addr_out_o(code_addr), .shadow_cancel_n_o(shadow_cancel_n_n),
        .exec_cancel_o(canc), .irq_entry_o(entry));
    irq_env_model env_u (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
        .ack_i(ack), .stall_i(stall), .line_n_o(line_n),
        .stall_n_o(stall_n));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic conclude;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
        do begin
            @(posedge clk_i);
            k++;
        end while (rsp.ack !== 1'b1 && k < 40);
        q = rsp.dat;
        req <= '0;
        @(posedge clk_i);
        if (k >= 40) begin
            n_fail++;
            conclude();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
        chk(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic wait_entry;
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (entry !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            conclude();
        end
    endtask

    task automatic quiet(input int c);
        int e;
        e = 0;
        repeat (c) begin
            @(posedge clk_i);
            if (entry !== 1'b0) e++;
        end
        chk(32'(e), 32'h0000_0000);
    endtask

    initial begin
        n_fail = 0;
        checks = 0;
        rst_i = 1'b1;
        req = '0;
        op = '0;
        op.next_addr = 22'h00_0040;
        timer = 1'b0;
        raise = 3'b000;
        ack = 3'b000;
        stall = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFF_SSR, SSR_RESET);
        rd(OFF_IEA, 32'h0000_0000);
        rd(OFF_IFA, 32'h0000_0000);
        rd(8'h1c, 32'h0000_0000);
        bus(1'b1, OFF_IBR, 32'hffff_ffff, 4'h1);
        rd(OFF_IBR, 32'h0000_00ff);
        wr(OFF_IEA, 32'h0000_1234);
        rd(OFF_IEA, 32'h0000_0000);
        $display("test registers done");
        // enables set but master enable clear: record only
        wr(OFF_SSR, SSR_RESET | 32'h0230_0000);
        raise <= 3'b110;
        @(posedge clk_i);
        raise <= 3'b000;
        quiet(10);
        rd(OFF_SSR, SSR_RESET | 32'h0278_0000);
        ack <= 3'b110;
        @(posedge clk_i);
        ack <= 3'b000;
        repeat (8) @(posedge clk_i);
        rd(OFF_SSR, SSR_RESET | 32'h0278_0000);
        bus(1'b1, OFF_SSR, SSR_RESET, 4'h7);
        rd(OFF_SSR, SSR_RESET | 32'h0278_0000);
        wr(OFF_SSR, SSR_RESET);
        rd(OFF_SSR, SSR_RESET);
        $display("test flags done");
        wr(OFF_IBR, 32'h0000_0100);
        wr(OFF_SSR, SSR_RESET | MEN | 32'h0001_0400);
        op.trap <= 1'b1;
        timer <= 1'b1;
        op.next_addr <= 22'h00_0080;
        @(posedge clk_i);
        op.trap <= 1'b0;
        timer <= 1'b0;
        op.next_addr <= 22'h00_00c0;
        @(posedge clk_i);
        chk({31'h0, entry}, 32'h0000_0001);
        chk({10'h0, code_addr}, 32'h0000_0100
            | {28'h0, CLASS_MAP_DEF[4*SRC_TRP +: 4]
               | CLASS_MAP_DEF[4*SRC_TIM +: 4]});
        chk({31'h0, shadow_cancel_n_n}, 32'h0000_0000);
        rd(OFF_IEA, 32'h0000_0040);
        rd(OFF_IFA, 32'h0000_0080);
        bus(1'b0, OFF_SSR, 32'h0000_0000, 4'hf);
        chk(q & 32'h0400_8200, 32'h0000_8200);
        op.ret_first <= 1'b1;
        @(posedge clk_i);
        op.ret_first <= 1'b0;
        op.ret_second <= 1'b1;
        @(posedge clk_i);
        op.ret_second <= 1'b0;
        chk({10'h0, code_addr}, 32'h0000_0040);
        chk({31'h0, shadow_cancel_n_n}, 32'h0000_0000);
        @(posedge clk_i);
        chk({10'h0, code_addr}, 32'h0000_0080);
        bus(1'b0, OFF_SSR, 32'h0000_0000, 4'hf);
        chk(q & MEN, MEN);
        wr(OFF_SSR, SSR_RESET);
        $display("test entry and return done");
        stall <= 1'b1;
        // model register, three sync stages, the sync output register, then the cancel register
        repeat (7) @(posedge clk_i);
        chk({31'h0, canc}, 32'h0000_0001);
        op.next_addr <= 22'h00_0100;
        repeat (3) @(posedge clk_i);
        chk({10'h0, code_addr}, 32'h0000_00c0);
        op.trap <= 1'b1;
        @(posedge clk_i);
        op.trap <= 1'b0;
        rd(OFF_SSR, SSR_RESET);
        op.ret_first <= 1'b1;
        @(posedge clk_i);
        op.ret_first <= 1'b0;
        @(posedge clk_i);
        chk({10'h0, code_addr}, 32'h0000_0040);
        wr(OFF_SSR, SSR_RESET | MEN | 32'h0200_0000);
        raise <= 3'b001;
        @(posedge clk_i);
        raise <= 3'b000;
        wait_entry();
        chk({10'h0, code_addr}, 32'h0000_0108);
        ack <= 3'b001;
        stall <= 1'b0;
        @(posedge clk_i);
        ack <= 3'b000;
        repeat (8) @(posedge clk_i);
        chk({10'h0, code_addr}, 32'h0000_0100);
        $display("test stall done");
        for (int i = 0; i < 5; i++) begin
            wr(OFF_SSR, {tv[i], 27'h000_0010});
            if (i < 2)
                op.push <= 1'b1;
            else
                op.pop <= 1'b1;
            @(posedge clk_i);
            op.push <= 1'b0;
            op.pop <= 1'b0;
            bus(1'b0, OFF_SSR, 32'h0000_0000, 4'hf);
            chk(q & 32'h0000_2800, ev[i]);
        end
        $display("test stack done");
        wr(OFF_SSR, SSR_RESET);
        op.branch <= 1'b1;
        @(posedge clk_i);
        op.branch <= 1'b0;
        op.invert_shadow <= 1'b1;
        @(posedge clk_i);
        chk({31'h0, shadow_cancel_n_n}, 32'h0000_0000);
        op.invert_shadow <= 1'b0;
        op.branch <= 1'b1;
        op.keep_shadow <= 1'b1;
        @(posedge clk_i);
        chk({31'h0, shadow_cancel_n_n}, 32'h0000_0000);
        op.keep_shadow <= 1'b0;
        op.keep_shadow_inc <= 1'b1;
        @(posedge clk_i);
        chk({31'h0, shadow_cancel_n_n}, 32'h0000_0001);
        op.branch <= 1'b0;
        op.keep_shadow_inc <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, shadow_cancel_n_n}, 32'h0000_0001);
        // pointer wraps from empty (all ones) to zero
        rd(OFF_SSR, 32'h0000_0010);
        $display("test shadow done");
        wr(OFF_BRK, 32'h0000_0100);
        wr(OFF_SSR, SSR_RESET);
        repeat (3) @(posedge clk_i);
        rd(OFF_SSR, SSR_RESET);
        wr(OFF_SSR, SSR_RESET | 32'h0000_0080);
        repeat (3) @(posedge clk_i);
        bus(1'b0, OFF_SSR, 32'h0000_0000, 4'hf);
        chk(q & 32'h0000_0040, 32'h0000_0040);
        // b set by the write must be copied into bi on entry
        wr(OFF_SSR, SSR_RESET | MEN | 32'h0000_0084);
        wait_entry();
        chk({10'h0, code_addr}, 32'h0000_0101);
        bus(1'b0, OFF_SSR, 32'h0000_0000, 4'hf);
        chk(q & 32'h0000_0008, 32'h0000_0008);
        $display("test breakpoint done");
        conclude();
    end
endmodule // tb
